// File: verilog/decoder_regs.svh
// Constants for the instruction decoder and cycle sequencer.
// Assumes inclusion by bare name from the decoder design files.
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

// ****************************************
// Instruction word layout
// ****************************************
`define DEC_WORD_W 14
`define DEC_DEST_BIT 7
`define DEC_FILE_W 7
`define DEC_BIT_LSB 7
`define DEC_LIT_W 8
`define DEC_TARGET_W 11

// ****************************************
// Cycle timing
// ****************************************
`define DEC_PHASE_LAST 2'h3

// ****************************************
// File register map defaults
// ****************************************
`define DEC_TIMER_ADDR 7'h01
`define DEC_PORT_A_ADDR 7'h05
`define DEC_PORT_B_ADDR 7'h06

// ****************************************
// Verify space
// ****************************************
`define DEC_ID_FIRST 14'h2000
`define DEC_ID_LAST 14'h2003
`define DEC_ID_BITS 4

// ****************************************
// Reset values
// ****************************************
`define DEC_EXPIRY_RESET 1'b1
`define DEC_STANDBY_RESET 1'b1

`endif

// File: verilog/decoder_pkg.sv
// Types shared by the instruction decoder files.
// Assumes compilation before the design modules.
package decoder_pkg;

   typedef enum logic [5:0] {
      OP_IDLE_OP = 6'h00,
      OP_ADD_ACC_AND_FILE = 6'h01,
      OP_AND_ACC_WITH_FILE = 6'h02,
      OP_ZERO_FILE = 6'h03,
      OP_ZERO_ACC = 6'h04,
      OP_INVERT_FILE = 6'h05,
      OP_MINUS_ONE_FILE = 6'h06,
      OP_MINUS_ONE_SKIP_ZERO = 6'h07,
      OP_PLUS_ONE_FILE = 6'h08,
      OP_PLUS_ONE_SKIP_ZERO = 6'h09,
      OP_OR_ACC_WITH_FILE = 6'h0A,
      OP_COPY_FILE = 6'h0B,
      OP_STORE_ACC_TO_FILE = 6'h0C,
      OP_ROTATE_LEFT_CARRY = 6'h0D,
      OP_ROTATE_RIGHT_CARRY = 6'h0E,
      OP_FILE_MINUS_ACC = 6'h0F,
      OP_NIBBLE_EXCHANGE = 6'h10,
      OP_XOR_ACC_WITH_FILE = 6'h11,
      OP_BIT_ZERO_OP = 6'h12,
      OP_BIT_ONE_OP = 6'h13,
      OP_TEST_SKIP_IF_ZERO = 6'h14,
      OP_TEST_SKIP_IF_ONE = 6'h15,
      OP_ADD_LITERAL_ACC = 6'h16,
      OP_AND_LITERAL_ACC = 6'h17,
      OP_SUBROUTINE_CALL = 6'h18,
      OP_WATCHDOG_KICK = 6'h19,
      OP_ABSOLUTE_JUMP = 6'h1A,
      OP_OR_LITERAL_ACC = 6'h1B,
      OP_LOAD_LITERAL_ACC = 6'h1C,
      OP_INTERRUPT_EXIT = 6'h1D,
      OP_EXIT_WITH_LITERAL = 6'h1E,
      OP_SUBROUTINE_EXIT = 6'h1F,
      OP_STANDBY = 6'h20,
      OP_LITERAL_MINUS_ACC = 6'h21,
      OP_XOR_LITERAL_ACC = 6'h22
   } op_t;

   typedef enum logic [0:0] {
      SEQ_EXEC = 1'b0,
      SEQ_FLUSH = 1'b1
   } seq_t;

endpackage

// File: verilog/op_classifier.sv
// Combinational split of one instruction word into operation and fields.
// Assumes the word on the fetch input is stable until the sequencer's cycle end.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_regs.svh"

module op_classifier
   import decoder_pkg::*;
(
   // Instruction word
   input wire logic [`DEC_WORD_W-1:0] word,
   // Operation and operands
   output op_t op,
   output logic dest_file,
   output logic [`DEC_FILE_W-1:0] file_addr,
   output logic [2:0] bit_num,
   output logic [`DEC_LIT_W-1:0] literal,
   output logic [`DEC_TARGET_W-1:0] target,
   // Side effects
   output logic reads_file,
   output logic writes_file,
   output logic upd_c,
   output logic upd_dc,
   output logic upd_z,
   output logic upd_to_pd,
   output logic two_cycle
);

   // ****************************************
   // Field extraction
   // ****************************************
   assign file_addr = word[`DEC_FILE_W-1:0];
   assign bit_num = word[`DEC_BIT_LSB+2:`DEC_BIT_LSB];
   assign literal = word[`DEC_LIT_W-1:0];
   assign target = word[`DEC_TARGET_W-1:0];
   assign dest_file = word[`DEC_DEST_BIT];

   // ****************************************
   // Opcode match, don't-care bits as ?
   // ****************************************
   always_comb begin
      op = OP_IDLE_OP;
      casez (word)
         14'b00_0111_????_????: op = OP_ADD_ACC_AND_FILE;
         14'b00_0101_????_????: op = OP_AND_ACC_WITH_FILE;
         14'b00_0100_????_????: op = OP_OR_ACC_WITH_FILE;
         14'b00_0110_????_????: op = OP_XOR_ACC_WITH_FILE;
         14'b00_0010_????_????: op = OP_FILE_MINUS_ACC;
         14'b00_1001_????_????: op = OP_INVERT_FILE;
         14'b00_0011_????_????: op = OP_MINUS_ONE_FILE;
         14'b00_1010_????_????: op = OP_PLUS_ONE_FILE;
         14'b00_1011_????_????: op = OP_MINUS_ONE_SKIP_ZERO;
         14'b00_1111_????_????: op = OP_PLUS_ONE_SKIP_ZERO;
         14'b00_1000_????_????: op = OP_COPY_FILE;
         14'b00_1101_????_????: op = OP_ROTATE_LEFT_CARRY;
         14'b00_1100_????_????: op = OP_ROTATE_RIGHT_CARRY;
         14'b00_1110_????_????: op = OP_NIBBLE_EXCHANGE;
         14'b00_0001_1???_????: op = OP_ZERO_FILE;
         14'b00_0001_0???_????: op = OP_ZERO_ACC;
         14'b00_0000_1???_????: op = OP_STORE_ACC_TO_FILE;
         14'b00_0000_0110_0100: op = OP_WATCHDOG_KICK;
         14'b00_0000_0110_0011: op = OP_STANDBY;
         14'b00_0000_0000_1001: op = OP_INTERRUPT_EXIT;
         14'b00_0000_0000_1000: op = OP_SUBROUTINE_EXIT;
         14'b01_00??_????_????: op = OP_BIT_ZERO_OP;
         14'b01_01??_????_????: op = OP_BIT_ONE_OP;
         14'b01_10??_????_????: op = OP_TEST_SKIP_IF_ZERO;
         14'b01_11??_????_????: op = OP_TEST_SKIP_IF_ONE;
         14'b10_0???_????_????: op = OP_SUBROUTINE_CALL;
         14'b10_1???_????_????: op = OP_ABSOLUTE_JUMP;
         14'b11_00??_????_????: op = OP_LOAD_LITERAL_ACC;
         14'b11_01??_????_????: op = OP_EXIT_WITH_LITERAL;
         14'b11_1000_????_????: op = OP_OR_LITERAL_ACC;
         14'b11_1001_????_????: op = OP_AND_LITERAL_ACC;
         14'b11_1010_????_????: op = OP_XOR_LITERAL_ACC;
         14'b11_110?_????_????: op = OP_LITERAL_MINUS_ACC;
         14'b11_111?_????_????: op = OP_ADD_LITERAL_ACC;
         default: op = OP_IDLE_OP;
      endcase
   end

   // ****************************************
   // Flags, file access and cycle count
   // ****************************************
   always_comb begin
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      upd_to_pd = 1'b0;
      two_cycle = 1'b0;
      reads_file = 1'b0;
      writes_file = 1'b0;
      case (op)
         OP_ADD_ACC_AND_FILE, OP_FILE_MINUS_ACC: begin
            {upd_c, upd_dc, upd_z} = 3'h7;
            reads_file = 1'b1;
            writes_file = dest_file;
         end
         OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE, OP_INVERT_FILE,
         OP_MINUS_ONE_FILE, OP_PLUS_ONE_FILE, OP_COPY_FILE: begin
            upd_z = 1'b1;
            reads_file = 1'b1;
            writes_file = dest_file;
         end
         OP_MINUS_ONE_SKIP_ZERO, OP_PLUS_ONE_SKIP_ZERO, OP_NIBBLE_EXCHANGE: begin
            reads_file = 1'b1;
            writes_file = dest_file;
         end
         OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
            upd_c = 1'b1;
            reads_file = 1'b1;
            writes_file = dest_file;
         end
         OP_ZERO_FILE: begin
            upd_z = 1'b1;
            writes_file = 1'b1;
         end
         OP_ZERO_ACC, OP_AND_LITERAL_ACC, OP_OR_LITERAL_ACC, OP_XOR_LITERAL_ACC: begin
            upd_z = 1'b1;
         end
         OP_ADD_LITERAL_ACC, OP_LITERAL_MINUS_ACC: begin
            {upd_c, upd_dc, upd_z} = 3'h7;
         end
         OP_STORE_ACC_TO_FILE: begin
            writes_file = 1'b1;
         end
         OP_BIT_ZERO_OP, OP_BIT_ONE_OP: begin
            reads_file = 1'b1;
            writes_file = 1'b1;
         end
         OP_TEST_SKIP_IF_ZERO, OP_TEST_SKIP_IF_ONE: begin
            reads_file = 1'b1;
         end
         OP_WATCHDOG_KICK, OP_STANDBY: begin
            upd_to_pd = 1'b1;
         end
         OP_SUBROUTINE_CALL, OP_ABSOLUTE_JUMP, OP_EXIT_WITH_LITERAL,
         OP_INTERRUPT_EXIT, OP_SUBROUTINE_EXIT: begin
            two_cycle = 1'b1;
         end
         default: begin
            two_cycle = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

// File: verilog/instr_decoder.sv
// Instruction decoder and four-phase cycle sequencer of the core.
// Assumes fetch, datapath and watchdog signals are on the same clock.
//
// Function
// - Take one 14-bit word per fetch; split opcode from operand fields.
// - Destination bit 0 sends result to accumulator, 1 to file register.
// - File address is the low 7 bits, addresses 0 through 127.
// - A 3-bit bit number picks one bit of the 8-bit file register.
// - Literal is low byte; call and jump carry 11-bit targets, two cycles.
// - One cycle, two when test succeeds or PC changes; second is idle.
// - Each instruction cycle is exactly four oscillator periods.
// - Top 00 codes: add, and, or, xor, file minus acc, complement.
// - Top 00: decrement, increment, and skip-on-zero forms taking two cycles on a zero result.
// - Top 00: copy, rotates, swap, clears, store accumulator to file.
// - Top 01: clear bit, set bit, test-skip clear, test-skip set.
// - Top 11: literal load, exit with literal, or, and, xor, sub, add.
// - Fixed words: watchdog kick, standby, interrupt exit, subroutine exit.
// - Arithmetic sets C, DC, Z; logic Z; rotates C; kick/standby TO, PD.
// - Port read-modify-write takes operand from pin levels, not latch.
// - Writing timer count clears prescaler when assigned to timer.
// - Don't-care bits are ignored by the decoder.
// - ID words only in program/verify mode; low four bits only.
// - Program readout only when code protection is unprogrammed.
// - Standby clears watchdog, clears PD, sets TO, stops oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_regs.svh"

module instr_decoder
   import decoder_pkg::*;
#(
   parameter logic [`DEC_FILE_W-1:0] TIMER_ADDR = `DEC_TIMER_ADDR,
   parameter logic [`DEC_FILE_W-1:0] PORT_A_ADDR = `DEC_PORT_A_ADDR,
   parameter logic [`DEC_FILE_W-1:0] PORT_B_ADDR = `DEC_PORT_B_ADDR
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Fetch from program memory
   input wire logic fetch_valid,
   input wire logic [`DEC_WORD_W-1:0] fetch_word,
   // Datapath and system status
   input wire logic alu_zero,
   input wire logic tested_bit,
   input wire logic prescaler_on_timer,
   input wire logic wdt_timeout,
   input wire logic wake_event,
   // Program and verify access
   input wire logic prog_verify_mode,
   input wire logic code_protect_set,
   input wire logic [`DEC_WORD_W-1:0] verify_addr,
   input wire logic [`DEC_WORD_W-1:0] id_wdata_in,
   // Sequencer
   output logic [1:0] phase,
   output logic cycle_start,
   output logic flush,
   // Decoded instruction
   output op_t op,
   output logic dest_file,
   output logic [`DEC_FILE_W-1:0] file_addr,
   output logic [2:0] bit_num,
   output logic [`DEC_LIT_W-1:0] literal,
   output logic [`DEC_TARGET_W-1:0] target,
   output logic writes_file,
   output logic upd_c,
   output logic upd_dc,
   output logic upd_z,
   output logic two_cycle,
   output logic use_pin_levels,
   // Side effects
   output logic clear_prescaler,
   output logic watchdog_clear,
   output logic osc_stop,
   output logic watchdog_expiry_flag,
   output logic standby_entered_flag,
   // Verify gating
   output logic readout_enable,
   output logic id_access_enable,
   output logic [`DEC_WORD_W-1:0] id_wdata
);

   function automatic logic is_port(input logic [`DEC_FILE_W-1:0] addr);
      is_port = (addr == PORT_A_ADDR) || (addr == PORT_B_ADDR);
   endfunction

   // ****************************************
   // Combinational decode of the fetched word
   // ****************************************
   op_t dec_op;
   logic dec_dest, dec_reads, dec_writes, dec_c, dec_dc, dec_z, dec_to_pd, dec_two;
   logic [`DEC_FILE_W-1:0] dec_addr;
   logic [2:0] dec_bit;
   logic [`DEC_LIT_W-1:0] dec_lit;
   logic [`DEC_TARGET_W-1:0] dec_target;

   op_classifier u_classifier (
      .word(fetch_word),
      .op(dec_op),
      .dest_file(dec_dest),
      .file_addr(dec_addr),
      .bit_num(dec_bit),
      .literal(dec_lit),
      .target(dec_target),
      .reads_file(dec_reads),
      .writes_file(dec_writes),
      .upd_c(dec_c),
      .upd_dc(dec_dc),
      .upd_z(dec_z),
      .upd_to_pd(dec_to_pd),
      .two_cycle(dec_two)
   );

   // ****************************************
   // Sequencer and decoded registers
   // ****************************************
   seq_t seq, next_seq;
   logic [1:0] next_phase;
   logic next_cycle_start, next_flush, end_of_cycle, taken;
   op_t next_op;
   logic next_dest, next_writes, next_c, next_dc, next_z, next_two, next_pins;
   logic [`DEC_FILE_W-1:0] next_addr;
   logic [2:0] next_bit;
   logic [`DEC_LIT_W-1:0] next_lit;
   logic [`DEC_TARGET_W-1:0] next_target;

   always_comb begin
      end_of_cycle = (phase == `DEC_PHASE_LAST) && !osc_stop;
      next_phase = osc_stop ? phase : phase + 2'h1;
      next_cycle_start = end_of_cycle;
      taken = 1'b0;
      if (seq == SEQ_EXEC) begin
         taken = two_cycle
            || ((op == OP_MINUS_ONE_SKIP_ZERO || op == OP_PLUS_ONE_SKIP_ZERO) && alu_zero)
            || (op == OP_TEST_SKIP_IF_ZERO && !tested_bit)
            || (op == OP_TEST_SKIP_IF_ONE && tested_bit);
      end
      next_seq = seq;
      next_flush = flush;
      next_op = op;
      next_dest = dest_file;
      next_addr = file_addr;
      next_bit = bit_num;
      next_lit = literal;
      next_target = target;
      next_writes = writes_file;
      next_c = upd_c;
      next_dc = upd_dc;
      next_z = upd_z;
      next_two = two_cycle;
      next_pins = use_pin_levels;
      if (end_of_cycle) begin
         case (seq)
            SEQ_EXEC: next_seq = taken ? SEQ_FLUSH : SEQ_EXEC;
            SEQ_FLUSH: next_seq = SEQ_EXEC;
            default: next_seq = SEQ_EXEC;
         endcase
         if ((seq == SEQ_EXEC && taken) || !fetch_valid) begin
            // Discarded or missing word runs as idle
            next_flush = (seq == SEQ_EXEC) && taken;
            next_op = OP_IDLE_OP;
            next_dest = 1'b0;
            next_addr = '0;
            next_bit = 3'h0;
            next_lit = '0;
            next_target = '0;
            next_writes = 1'b0;
            {next_c, next_dc, next_z} = 3'h0;
            next_two = 1'b0;
            next_pins = 1'b0;
         end else begin
            next_flush = 1'b0;
            next_op = dec_op;
            next_dest = dec_dest;
            next_addr = dec_addr;
            next_bit = dec_bit;
            next_lit = dec_lit;
            next_target = dec_target;
            next_writes = dec_writes;
            next_c = dec_c;
            next_dc = dec_dc;
            next_z = dec_z;
            next_two = dec_two;
            next_pins = dec_reads && dec_writes && is_port(dec_addr);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         seq <= SEQ_EXEC;
         phase <= 2'h0;
         cycle_start <= 1'b0;
         flush <= 1'b0;
         op <= OP_IDLE_OP;
         dest_file <= 1'b0;
         file_addr <= '0;
         bit_num <= 3'h0;
         literal <= '0;
         target <= '0;
         writes_file <= 1'b0;
         upd_c <= 1'b0;
         upd_dc <= 1'b0;
         upd_z <= 1'b0;
         two_cycle <= 1'b0;
         use_pin_levels <= 1'b0;
      end else begin
         seq <= next_seq;
         phase <= next_phase;
         cycle_start <= next_cycle_start;
         flush <= next_flush;
         op <= next_op;
         dest_file <= next_dest;
         file_addr <= next_addr;
         bit_num <= next_bit;
         literal <= next_lit;
         target <= next_target;
         writes_file <= next_writes;
         upd_c <= next_c;
         upd_dc <= next_dc;
         upd_z <= next_z;
         two_cycle <= next_two;
         use_pin_levels <= next_pins;
      end
   end

   // ****************************************
   // Completion effects and power status
   // ****************************************
   logic next_clr_pre, next_wdt_clr, next_stop, next_expiry, next_standby;
   logic done_kick, done_standby;

   always_comb begin
      done_kick = end_of_cycle && seq == SEQ_EXEC && op == OP_WATCHDOG_KICK;
      done_standby = end_of_cycle && seq == SEQ_EXEC && op == OP_STANDBY;
      next_clr_pre = end_of_cycle && seq == SEQ_EXEC && writes_file
         && file_addr == TIMER_ADDR && prescaler_on_timer;
      next_wdt_clr = done_kick || done_standby;
      next_stop = (osc_stop || done_standby) && !wake_event;
      next_expiry = watchdog_expiry_flag;
      next_standby = standby_entered_flag;
      if (done_kick) begin
         next_expiry = 1'b1;
         next_standby = 1'b1;
      end
      if (done_standby) begin
         next_expiry = 1'b1;
         next_standby = 1'b0;
      end
      if (wdt_timeout) begin
         next_expiry = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         clear_prescaler <= 1'b0;
         watchdog_clear <= 1'b0;
         osc_stop <= 1'b0;
         watchdog_expiry_flag <= `DEC_EXPIRY_RESET;
         standby_entered_flag <= `DEC_STANDBY_RESET;
      end else begin
         clear_prescaler <= next_clr_pre;
         watchdog_clear <= next_wdt_clr;
         osc_stop <= next_stop;
         watchdog_expiry_flag <= next_expiry;
         standby_entered_flag <= next_standby;
      end
   end

   // ****************************************
   // Verify readout and ID gating
   // ****************************************
   logic next_readout, next_id_ok;
   logic [`DEC_WORD_W-1:0] next_id_wdata;

   always_comb begin
      next_readout = prog_verify_mode && !code_protect_set
         && verify_addr < `DEC_ID_FIRST;
      next_id_ok = prog_verify_mode && verify_addr >= `DEC_ID_FIRST
         && verify_addr <= `DEC_ID_LAST;
      next_id_wdata = '0;
      if (next_id_ok) begin
         next_id_wdata[`DEC_ID_BITS-1:0] = id_wdata_in[`DEC_ID_BITS-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         readout_enable <= 1'b0;
         id_access_enable <= 1'b0;
         id_wdata <= '0;
      end else begin
         readout_enable <= next_readout;
         id_access_enable <= next_id_ok;
         id_wdata <= next_id_wdata;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   AST_PHASE_WRAP: assert property (phase == 2'h3 && !osc_stop |=> phase == 2'h0)
      else $error("phase did not wrap after four periods");
   AST_CYCLE_PERIOD: assert property (cycle_start && !osc_stop |=>
      !cycle_start [*3] ##1 (cycle_start || osc_stop))
      else $error("instruction cycle not four clocks");
   AST_FLUSH_IDLE: assert property (flush |-> op == OP_IDLE_OP && !writes_file)
      else $error("flushed cycle not idle");
   AST_JUMP_TWO: assert property (end_of_cycle && seq == SEQ_EXEC
      && (op == OP_ABSOLUTE_JUMP || op == OP_SUBROUTINE_CALL) |=> flush)
      else $error("jump or call did not take a second cycle");
   AST_SKIP_COUNT: assert property (end_of_cycle && seq == SEQ_EXEC
      && op == OP_MINUS_ONE_SKIP_ZERO && alu_zero |=> flush ##4 !flush)
      else $error("zero result did not skip exactly one cycle");
   AST_TEST_SKIP: assert property (end_of_cycle && seq == SEQ_EXEC
      && op == OP_TEST_SKIP_IF_ONE && !tested_bit |=> !flush)
      else $error("test skipped on wrong bit value");
   AST_ONE_CYCLE: assert property (end_of_cycle && seq == SEQ_EXEC && !two_cycle
      && op == OP_ADD_ACC_AND_FILE |=> !flush)
      else $error("plain instruction took two cycles");
   AST_STANDBY: assert property (done_standby && !wake_event && !wdt_timeout |=>
      watchdog_clear && osc_stop && watchdog_expiry_flag && !standby_entered_flag)
      else $error("standby effects missing");
   AST_PRESCALER: assert property (end_of_cycle && seq == SEQ_EXEC && writes_file
      && file_addr == TIMER_ADDR && prescaler_on_timer |=> clear_prescaler)
      else $error("timer write did not clear prescaler");
   AST_READOUT: assert property (readout_enable |->
      $past(prog_verify_mode) && !$past(code_protect_set))
      else $error("readout allowed while protected");
   AST_ID_GATE: assert property (id_access_enable |-> $past(prog_verify_mode)
      && id_wdata[`DEC_WORD_W-1:`DEC_ID_BITS] == '0)
      else $error("id access outside verify mode");

   COV_SKIP: cover property (end_of_cycle && op == OP_TEST_SKIP_IF_ZERO ##1 flush);
   COV_CALL: cover property (end_of_cycle && op == OP_SUBROUTINE_CALL ##1 flush);
   COV_STANDBY: cover property (osc_stop ##[1:20] !osc_stop);
   COV_PORT_RMW: cover property (use_pin_levels);

endmodule
`default_nettype wire

// File: test/prog_mem_model.sv
// Program memory model: one instruction word per instruction cycle.
// Assumes the bench preloads mem, each entry {valid, word}, before reset ends.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Sequencer state
   input wire logic [1:0] phase,
   input wire logic osc_stop,
   // Fetch
   output logic fetch_valid,
   output logic [13:0] fetch_word
);
   logic [14:0] mem [0:127];
   logic [6:0] ptr;
   // Advance at every cycle end while running, even when the word is discarded
   always_ff @(posedge clock) begin
      if (!rstn) ptr <= 7'h00;
      else if (phase == 2'h3 && !osc_stop) ptr <= ptr + 7'h01;
   end
   assign {fetch_valid, fetch_word} = mem[ptr];
endmodule
`default_nettype wire

// File: test/test_instr_decoder.sv
// Self-checking bench for the instruction decoder and sequencer.
// Assumes the package and the program memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_instr_decoder;
   import decoder_pkg::*;
   logic clock = 0, rstn = 0, az = 0, tb = 0, wdt = 0, wake = 0, pvm = 0, prot = 0;
   logic fv, cs, fl, two, uc, udc, uz, pins, wclr, cpre, stop, expf, sbf, ro, ida;
   logic stopped = 1, armed = 0, sb = 0, pre = 0, dst;
   logic [6:0] fa;
   logic [2:0] bn;
   logic [10:0] tg;
   logic [14:0] mw;
   logic [13:0] fw, idw, vaddr = 0, vdata = 0;
   logic [1:0] ph;
   logic [2:0] cz [0:127];
   op_t op;
   logic [7:0] lit;
   logic [20:0] want;
   logic [20:0] q[$];
   logic [31:0] seed = 32'hF7188727;
   int errors = 0, check_count = 0, n_wclr = 0, n_pre = 0, e_wclr = 0, e_pre = 0;
   int ticks = 0, gap = 0, k = 0;
   // {two,c,dc,z} {rnd,pins,0,timer} op word
   logic [31:0] tab [0:38] = '{32'h78010780, 32'h18020500, 32'h18030180, 32'h18040100,
      32'h18050900, 32'h18060300, 32'h08070B00, 32'h18080A00, 32'h08090F00, 32'h180A0400,
      32'h180B0800, 32'h080C0080, 32'h480D0D00, 32'h480E0C00, 32'h780F0200, 32'h08100E00,
      32'h18110600, 32'h08121000, 32'h08131400, 32'h08141800, 32'h08151C00, 32'h78163F00,
      32'h18173900, 32'h88182000, 32'h00190064, 32'h881A2800, 32'h181B3800, 32'h081C3300,
      32'h801D0009, 32'h881E3700, 32'h801F0008, 32'h00200063, 32'h78213D00, 32'h18223A00,
      32'h00000060, 32'h00000001, 32'h14080A86, 32'h110B0881, 32'h11030181};
   prog_mem_model u_prog_mem_model (.clock(clock), .rstn(rstn), .phase(ph), .osc_stop(stop),
      .fetch_valid(fv), .fetch_word(fw));
   instr_decoder u_instr_decoder (.clock(clock), .rstn(rstn), .fetch_valid(fv),
      .fetch_word(fw), .alu_zero(az), .tested_bit(tb), .prescaler_on_timer(pre),
      .wdt_timeout(wdt), .wake_event(wake), .prog_verify_mode(pvm), .code_protect_set(prot),
      .verify_addr(vaddr), .id_wdata_in(vdata), .phase(ph), .cycle_start(cs), .flush(fl),
      .op(op), .dest_file(dst), .file_addr(fa), .bit_num(bn), .literal(lit), .target(tg),
      .writes_file(), .upd_c(uc), .upd_dc(udc), .upd_z(uz), .two_cycle(two),
      .use_pin_levels(pins), .clear_prescaler(cpre), .watchdog_clear(wclr), .osc_stop(stop),
      .watchdog_expiry_flag(expf), .standby_entered_flag(sbf), .readout_enable(ro),
      .id_access_enable(ida), .id_wdata(idw));
   task automatic check(input logic [20:0] seen, input logic [20:0] exp_v);
      check_count++;
      if (seen !== exp_v) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp_v);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always #5 clock = ~clock;
   always @(posedge clock) #1 wake = stop;
   always @(posedge clock) begin
      ticks++;
      if (ticks == 20000) begin
         errors++;
         end_sim();
      end
   end
   // Stream monitor: one note per instruction cycle
   always @(posedge clock) begin
      gap++;
      n_wclr += int'(wclr === 1'b1);
      n_pre += int'(cpre === 1'b1);
      if (stop === 1'b1) stopped = 1;
      if (cs === 1'b1) armed = 1;
      if (armed && ph === 2'h1 && q.size() > 0) begin
         want = q.pop_front();
         if (!stopped) check(21'(gap), 21'h4);
         gap = 0;
         stopped = 0;
         check({1'b0, fl, op, 13'h0}, {1'b0, want[19:13], 13'h0});
         if (want[20]) check({1'b1, fl, op, two, uc, udc, uz, pins, lit}, want);
         mw = u_prog_mem_model.mem[k];
         if (want[20]) check({fa, bn, tg}, {mw[6:0], mw[9:7], mw[10:0]});
         if (want[20]) check(21'(dst), 21'(mw[7]));
         #1 {pre, az, tb} = cz[k];
         k++;
      end
   end
   initial begin
      logic [31:0] e;
      logic [13:0] w;
      logic taken, v;
      taken = 0;
      for (int i = 0; i < 128; i++) u_prog_mem_model.mem[i] = 15'h0;
      for (int i = 0; i < 80; i++) begin
         seed = lfsr(seed);
         e = tab[i < 39 ? i : seed[21:16] % 39];
         w = e[13:0] | (e[27] ? seed[13:0] & 14'h0078 : 14'h0);
         v = i < 39 || seed[30:28] != 3'h0;
         cz[i] = seed[26:24];
         u_prog_mem_model.mem[i] = {v, w};
         if (taken || !v) q.push_back({1'b0, taken, 19'h0});
         else q.push_back({2'b10, e[21:16], e[31:28], e[26], w[7:0]});
         if (!taken && v) begin
            e_wclr += int'(e[21:16] == 6'h19 || e[21:16] == 6'h20);
            e_pre += int'(e[24] && cz[i][2]);
            if (e[21:16] == 6'h19 || e[21:16] == 6'h20) sb = e[21:16] == 6'h20;
            taken = e[31] || ((e[21:16] == 6'h07 || e[21:16] == 6'h09) && cz[i][1])
               || (e[21:16] == 6'h14 && !cz[i][0]) || (e[21:16] == 6'h15 && cz[i][0]);
         end
         else taken = 0;
      end
      repeat (12) @(posedge clock);
      #1 rstn = 1;
      while (q.size() > 0) @(posedge clock);
      repeat (8) @(posedge clock);
      check(21'(n_wclr), 21'(e_wclr));
      check(21'(n_pre), 21'(e_pre));
      check({19'h0, expf, sbf}, {19'h0, 1'b1, !sb});
      #1 wdt = 1;
      @(posedge clock) #1 wdt = 0;
      check(21'(expf), 21'h0);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         vaddr = i[1] ? (i[0] ? 14'h2004 : 14'h2003) : (i[0] ? 14'h2000 : 14'h1FFF);
         {prot, pvm} = 2'(i >> 2);
         vdata = seed[13:0];
         @(posedge clock) #1;
         v = pvm && vaddr >= 14'h2000 && vaddr <= 14'h2003;
         check({ro, ida, 5'h0, idw}, {pvm && !prot && vaddr < 14'h2000, v, 5'h0,
            v ? {10'h0, vdata[3:0]} : 14'h0});
      end
      end_sim();
   end
endmodule
`default_nettype wire
